//--- verilog/dpram_params.svh
`ifndef DPRAM_PARAMS_SVH
`define DPRAM_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define REG_CTRL 12'h000
`define REG_WADDR 12'h004
`define REG_WDATA 12'h008
`define REG_RADDR 12'h00C
`define REG_RDATA 12'h010
`define REG_STATUS 12'h014
`define REG_CLEAR 12'h018
`define REG_TAPS 12'h01C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_SHAPE_LSB 0
`define CTRL_MODE_LSB 3
`define CTRL_BYPASS_BIT 6
`define CTRL_RDCLK_BIT 7
`define CTRL_LOAD_BIT 8
`define CTRL_W 9
`define CTRL_RESET 9'h000
`define TAPS_RESET 9'h001
`define CLEAR_IN_BIT 0
`define CLEAR_OUT_BIT 1
`define STAT_DONE_BIT 0
`define STAT_EMPTY_BIT 1
`define STAT_FULL_BIT 2
`define STAT_LEVEL_LSB 3

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define ADDR_W 9
`define ROW_W 5
`define WORD_W 18
`define LEVEL_W 10
`define ROWS 32
`define ROWS_BASE 10'h020
`define ONE_LANE 18'h0_0001
`define ZERO_WORD 18'h0_0000
`define ZERO_BUS 32'h0000_0000

`endif

//--- verilog/dpram_pkg.sv
package dpram_pkg;
    typedef enum logic [2:0] {
        SHAPE_512X1, SHAPE_256X2, SHAPE_128X4, SHAPE_64X8,
        SHAPE_64X9, SHAPE_32X16, SHAPE_32X18
    } shape_t;
    typedef enum logic [2:0] {
        MODE_DUAL, MODE_SINGLE, MODE_FIFO, MODE_ROM, MODE_SHIFT
    } mode_t;
endpackage

//--- verilog/ram_array.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpram_params.svh"

module ram_array
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [`ROW_W-1:0] wr_row,
    input wire logic [`WORD_W-1:0] wr_data,
    input wire logic [`WORD_W-1:0] wr_mask,
    input wire logic rd_en,
    input wire logic [`ROW_W-1:0] rd_row,
    input wire logic rd_clr,
    output logic [`WORD_W-1:0] rd_word
);
    // ----------------------------------------
    // Storage, no reset on the array
    // ----------------------------------------
    logic [`WORD_W-1:0] mem [0:`ROWS-1];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_row] <= (mem[wr_row] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // ----------------------------------------
    // Registered read port
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_word <= `ZERO_WORD;
        end
        else if (rd_clr)
        begin
            rd_word <= `ZERO_WORD;
        end
        else if (rd_en)
        begin
            // Samples before the write lands: old data on collision
            rd_word <= mem[rd_row];
        end
    end
endmodule // ram_array

`default_nettype wire

//--- verilog/small_dual_port_ram_block.sv
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "dpram_params.svh"

module small_dual_port_ram_block
    import dpram_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ----------------------------------------
    // Shape helpers
    // ----------------------------------------
    // lane widths
    function automatic logic [4:0] lane_width(input shape_t s);
        case (s)
            SHAPE_512X1: lane_width = 5'd1;
            SHAPE_256X2: lane_width = 5'd2;
            SHAPE_128X4: lane_width = 5'd4;
            SHAPE_64X8: lane_width = 5'd8;
            SHAPE_64X9: lane_width = 5'd9;
            SHAPE_32X16: lane_width = 5'd16;
            default: lane_width = 5'd18;
        endcase
    endfunction

    // Log2 of lanes per 18-bit row
    function automatic logic [2:0] lane_log(input shape_t s);
        case (s)
            SHAPE_512X1: lane_log = 3'd4;
            SHAPE_256X2: lane_log = 3'd3;
            SHAPE_128X4: lane_log = 3'd2;
            SHAPE_64X8: lane_log = 3'd1;
            SHAPE_64X9: lane_log = 3'd1;
            default: lane_log = 3'd0;
        endcase
    endfunction

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic [`CTRL_W-1:0] ctrl;
    logic [`ADDR_W-1:0] waddr;
    logic [`ADDR_W-1:0] raddr;
    logic [`ADDR_W-1:0] taps;
    logic [`ADDR_W-1:0] wptr;
    logic [`ADDR_W-1:0] rptr;
    logic [`LEVEL_W-1:0] level;
    logic rd_done;

    // ----------------------------------------
    // Input, read and output registers
    // ----------------------------------------
    logic wren_q;
    logic [`ROW_W-1:0] wrow_q;
    logic [`WORD_W-1:0] wdata_q;
    logic [`WORD_W-1:0] wmask_q;
    logic rden_q;
    logic [`ROW_W-1:0] rrow_q;
    logic [4:0] roff_q;
    logic [4:0] roff2;
    logic word_valid;
    logic out_valid;
    logic in_clr_q;
    logic [`WORD_W-1:0] out_q;
    logic [`WORD_W-1:0] rd_word;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire shape_t shape = shape_t'(ctrl[`CTRL_SHAPE_LSB +: 3]);
    wire mode_t mode = mode_t'(ctrl[`CTRL_MODE_LSB +: 3]);
    wire bypass = ctrl[`CTRL_BYPASS_BIT];
    wire load_en = ctrl[`CTRL_LOAD_BIT];
    wire [4:0] width = lane_width(shape);
    wire [2:0] llog = lane_log(shape);
    wire [`LEVEL_W-1:0] depth = `ROWS_BASE << llog;
    wire [`ADDR_W-1:0] amask = `ADDR_W'(depth - 10'd1);
    wire [`WORD_W-1:0] lane_ones = (`ONE_LANE << width) - `ONE_LANE;

    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr_access = access & pwrite;
    wire dec_ctrl = paddr == `REG_CTRL;
    wire dec_waddr = paddr == `REG_WADDR;
    wire dec_wdata = paddr == `REG_WDATA;
    wire dec_raddr = paddr == `REG_RADDR;
    wire dec_rdata = paddr == `REG_RDATA;
    wire dec_status = paddr == `REG_STATUS;
    wire dec_clear = paddr == `REG_CLEAR;
    wire dec_taps = paddr == `REG_TAPS;
    wire mapped = dec_ctrl | dec_waddr | dec_wdata | dec_raddr | dec_rdata
        | dec_status | dec_clear | dec_taps;

    wire is_fifo = mode == MODE_FIFO;
    wire is_shift = mode == MODE_SHIFT;
    wire is_rom = mode == MODE_ROM;
    wire is_single = mode == MODE_SINGLE;
    wire fifo_empty = level == 10'd0;
    wire fifo_full = level == depth;

    // clears, driven from the clear register or logic
    wire clr_in = wr_access & dec_clear & pwdata[`CLEAR_IN_BIT];
    wire clr_out = wr_access & dec_clear & pwdata[`CLEAR_OUT_BIT];

    // ----------------------------------------
    // Write and read triggers
    // ----------------------------------------
    // ROM contents writable only during preload
    wire push_ok = is_fifo ? ~fifo_full : (is_rom ? load_en : 1'b1);
    // enables may be made by plain logic
    wire next_wren = wr_access & dec_wdata & push_ok;
    wire pop_ok = is_fifo ? ~fifo_empty : ~is_shift;
    // shift mode reads alongside each write
    wire next_rden = (wr_access & dec_raddr & pop_ok) | (next_wren & is_shift);

    wire [`ADDR_W-1:0] wr_addr = (is_fifo | is_shift) ? (wptr & amask) : waddr;
    wire [`ADDR_W-1:0] rd_addr = is_fifo ? (rptr & amask)
        : is_shift ? ((wptr - taps) & amask)
        : is_single ? waddr
        : pwdata[`ADDR_W-1:0];

    wire [`ROW_W-1:0] wr_row = `ROW_W'(wr_addr >> llog);
    wire [`ROW_W-1:0] rd_row = `ROW_W'(rd_addr >> llog);
    wire [3:0] wr_lane = 4'(wr_addr & ((`ADDR_W'(1) << llog) - `ADDR_W'(1)));
    wire [3:0] rd_lane = 4'(rd_addr & ((`ADDR_W'(1) << llog) - `ADDR_W'(1)));
    wire [4:0] wr_off = 5'(wr_lane * width);
    wire [4:0] rd_off = 5'(rd_lane * width);
    wire [`WORD_W-1:0] next_wmask = lane_ones << wr_off;
    wire [`WORD_W-1:0] next_wdata = (pwdata[`WORD_W-1:0] & lane_ones) << wr_off;

    // lane taken from the registered row
    wire [`WORD_W-1:0] lane_data = (rd_word >> roff2) & lane_ones;
    // only the output register is bypassable
    wire [`WORD_W-1:0] result = bypass ? lane_data : out_q;
    wire result_valid = bypass ? word_valid : out_valid;

    wire [31:0] status_word = {19'h0_0000, level, fifo_full, fifo_empty, rd_done};
    wire [31:0] rdata_mux = dec_ctrl ? {23'h00_0000, ctrl}
        : dec_waddr ? {23'h00_0000, waddr}
        : dec_raddr ? {23'h00_0000, raddr}
        : dec_rdata ? {14'h0000, result}
        : dec_status ? status_word
        : dec_taps ? {23'h00_0000, taps}
        : `ZERO_BUS;

    // ----------------------------------------
    // APB slave, zero wait states
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `ZERO_BUS;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= setup ? rdata_mux : prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= `CTRL_RESET;
            waddr <= '0;
            raddr <= '0;
            taps <= `TAPS_RESET;
        end
        else if (wr_access)
        begin
            ctrl <= dec_ctrl ? pwdata[`CTRL_W-1:0] : ctrl;
            waddr <= dec_waddr ? pwdata[`ADDR_W-1:0] : waddr;
            raddr <= dec_raddr ? pwdata[`ADDR_W-1:0] : raddr;
            taps <= dec_taps ? pwdata[`ADDR_W-1:0] : taps;
        end
    end

    // ----------------------------------------
    // FIFO and shift pointers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wptr <= '0;
            rptr <= '0;
            level <= '0;
        end
        else if (clr_in)
        begin
            wptr <= '0;
            rptr <= '0;
            level <= '0;
        end
        else
        begin
            wptr <= (next_wren & (is_fifo | is_shift)) ? ((wptr + 9'd1) & amask) : wptr;
            rptr <= (next_rden & is_fifo) ? ((rptr + 9'd1) & amask) : rptr;
            level <= (next_wren & is_fifo) ? level + 10'd1
                : (next_rden & is_fifo) ? level - 10'd1 : level;
        end
    end

    // ----------------------------------------
    // Input registers
    // ----------------------------------------
    // write side on one clock; read side, both clocks are pclk here
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wren_q <= 1'b0;
            wrow_q <= '0;
            wdata_q <= `ZERO_WORD;
            wmask_q <= `ZERO_WORD;
            rden_q <= 1'b0;
            rrow_q <= '0;
            roff_q <= '0;
            in_clr_q <= 1'b0;
        end
        else
        begin
            wren_q <= next_wren & ~clr_in;
            wrow_q <= clr_in ? '0 : wr_row;
            wdata_q <= clr_in ? `ZERO_WORD : next_wdata;
            wmask_q <= clr_in ? `ZERO_WORD : next_wmask;
            rden_q <= next_rden & ~clr_in;
            rrow_q <= clr_in ? '0 : rd_row;
            roff_q <= clr_in ? '0 : rd_off;
            in_clr_q <= clr_in;
        end
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    // 32 rows of 18 bits
    // cleared input shows at next edge
    ram_array u_ram
    (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(wren_q),
        .wr_row(wrow_q),
        .wr_data(wdata_q),
        .wr_mask(wmask_q),
        .rd_en(rden_q),
        .rd_row(rrow_q),
        .rd_clr(in_clr_q | clr_out),
        .rd_word(rd_word)
    );

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    // one or two cycles of latency
    // output clear takes effect at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            roff2 <= '0;
            word_valid <= 1'b0;
            out_valid <= 1'b0;
            out_q <= `ZERO_WORD;
        end
        else
        begin
            roff2 <= rden_q ? roff_q : roff2;
            word_valid <= rden_q & ~in_clr_q & ~clr_out;
            out_valid <= word_valid & ~clr_out;
            out_q <= clr_out ? `ZERO_WORD : (word_valid ? lane_data : out_q);
        end
    end

    // Sticky so software can poll across APB cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_done <= 1'b0;
        end
        else
        begin
            rd_done <= result_valid | (rd_done & ~next_rden & ~clr_in & ~clr_out);
        end
    end
endmodule // small_dual_port_ram_block

`default_nettype wire

//--- test/small_dual_port_ram_block_checker.sv
`timescale 1ns/10ps
`default_nettype none
module small_dual_port_ram_block_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    wire setup = psel && !penable;
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 12'h01C);
    wire oclr = setup && pwrite && (paddr == 12'h018) && pwdata[1];
    wire rdq = setup && !pwrite && (paddr == 12'h010);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (setup |=> pready)
        else $error("pready missing after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(setup))
        else $error("pready without setup");
    a_err_paired: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_unmapped: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_data_held: assert property (!setup |=> $stable(prdata))
        else $error("prdata moved outside setup");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:18] == 14'h0)
        else $error("upper read bits not zero");
    a_clear_shown: assert property (oclr ##[2:3] rdq |=> prdata == 32'h0000_0000)
        else $error("output clear not seen");
endmodule // small_dual_port_ram_block_checker
bind small_dual_port_ram_block small_dual_port_ram_block_checker chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- test/apb_user_model.sv
`timescale 1ns/10ps
`default_nettype none
module apb_user_model
(
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic stuck = 1'b0;
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        stuck = (k == 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines must not look valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // apb_user_model
`default_nettype wire

//--- test/small_dual_port_ram_block_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dpram_params.svh"
module small_dual_port_ram_block_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, d;
    logic [31:0] q[3];
    int n_errors, checked, seed, a;
    int wt[7] = '{1, 2, 4, 8, 9, 16, 18};
    int dt[7] = '{512, 256, 128, 64, 64, 32, 32};
    always #12.5 pclk = ~pclk;
    small_dual_port_ram_block uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    apb_user_model m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task wrap_up;
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task xf(input logic w, input logic [11:0] ad, input logic [31:0] dat);
        m.xfer(w, ad, dat, v, e);
        if (m.stuck)
        begin
            n_errors++;
            wrap_up();
        end
    endtask
    // Poll done, then fetch the result
    task fetch;
        int k;
        // Cleared first: a trigger's read-back is not status
        v = 32'h0;
        for (k = 0; k < 20 && v[0] !== 1'b1; k++)
            xf(1'b0, `REG_STATUS, 32'h0);
        check("done", {31'h0, v[0]}, 32'h1);
        xf(1'b0, `REG_RDATA, 32'h0);
    endtask
    // Trigger a read, then fetch it
    task get(input logic [31:0] ad);
        xf(1'b1, `REG_RADDR, ad);
        fetch();
    endtask
    function logic [31:0] lane(input int w, input logic [31:0] x);
        return x & ((32'h1 << w) - 32'h1);
    endfunction
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        seed = 90006;
        n_errors = 0;
        checked = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // ----
        // Reset values and refusal
        // ----
        xf(1'b0, `REG_CTRL, 32'h0);
        check("ctrl", v, 32'h0000_0000);
        xf(1'b0, `REG_TAPS, 32'h0);
        check("taps", v, 32'h0000_0001);
        xf(1'b0, `REG_RDATA, 32'h0);
        check("rdata", v, 32'h0000_0000);
        xf(1'b0, 12'h020, 32'h0);
        check("slverr", {31'h0, e}, 32'h1);
        // ----
        // Every shape, both output paths
        // ----
        for (int s = 0; s < 7; s++)
        begin
            xf(1'b1, `REG_CTRL, {25'h0, s[0], 3'h0, s[2:0]});
            repeat (3)
            begin
                a = {$random(seed)} % dt[s];
                d = $random(seed);
                xf(1'b1, `REG_WADDR, a);
                xf(1'b1, `REG_WDATA, d);
                get(a + dt[s]);
                check("shape", v, lane(wt[s], d));
            end
        end
        // ----
        // Preload, clears, single port, queue
        // ----
        d = $random(seed);
        xf(1'b1, `REG_CTRL, 32'h0000_011E);
        xf(1'b1, `REG_WADDR, 32'h5);
        xf(1'b1, `REG_WDATA, d);
        xf(1'b1, `REG_CTRL, 32'h0000_001E);
        xf(1'b1, `REG_WDATA, ~d);
        get(32'h5);
        check("rom", v, lane(18, d));
        xf(1'b1, `REG_CLEAR, 32'h2);
        xf(1'b0, `REG_RDATA, 32'h0);
        check("oclear", v, 32'h0000_0000);
        xf(1'b1, `REG_CTRL, 32'h0000_000E);
        xf(1'b1, `REG_WADDR, 32'h7);
        xf(1'b1, `REG_WDATA, d);
        get(32'h0);
        check("single", v, lane(18, d));
        xf(1'b1, `REG_CTRL, 32'h0000_0016);
        xf(1'b1, `REG_CLEAR, 32'h1);
        xf(1'b0, `REG_STATUS, 32'h0);
        check("empty", v, 32'h0000_0002);
        for (int i = 0; i < 3; i++)
        begin
            q[i] = $random(seed);
            xf(1'b1, `REG_WDATA, q[i]);
        end
        xf(1'b0, `REG_STATUS, 32'h0);
        check("level", v >> 3, 32'h3);
        for (int i = 0; i < 3; i++)
        begin
            get(32'h0);
            check("pop", v, lane(18, q[i]));
        end
        // ----
        // Shift taps, input clear, same-cycle collision
        // ----
        xf(1'b1, `REG_CTRL, 32'h0000_0066);
        xf(1'b1, `REG_CLEAR, 32'h1);
        xf(1'b1, `REG_TAPS, 32'h2);
        for (int i = 0; i < 3; i++)
        begin
            q[i] = $random(seed);
            xf(1'b1, `REG_WDATA, q[i]);
        end
        fetch();
        check("shift", v, lane(18, q[0]));
        xf(1'b1, `REG_CLEAR, 32'h1);
        xf(1'b0, `REG_RDATA, 32'h0);
        check("iclear", v, 32'h0000_0000);
        // Zero taps reads the entry being written
        xf(1'b1, `REG_TAPS, 32'h0);
        xf(1'b1, `REG_WDATA, ~q[0]);
        fetch();
        check("collide", v, lane(18, q[0]));
        wrap_up();
    end
endmodule // small_dual_port_ram_block_tb
`default_nettype wire
